/* File: dpg_cfg.svh */
// Register offsets, field positions, reset values and fixed codes of the PLL, gain and offset bank
`ifndef DPG_CFG_SVH
`define DPG_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define DPG_ADDR_PLL_CONTROL       8'h04
`define DPG_ADDR_I_FINE_GAIN       8'h05
`define DPG_ADDR_I_COARSE_GAIN     8'h06
`define DPG_ADDR_I_OFFSET_HIGH     8'h07
`define DPG_ADDR_I_OFFSET_LOW_DIR  8'h08
`define DPG_ADDR_Q_FINE_GAIN       8'h09
`define DPG_ADDR_Q_COARSE_GAIN     8'h0a
`define DPG_ADDR_Q_OFFSET_HIGH     8'h0b
`define DPG_ADDR_Q_OFFSET_LOW_DIR  8'h0c
`define DPG_ADDR_REVISION_ID       8'h0d

// ****************************************
// Field positions
// ****************************************
`define DPG_PLL_ENABLE_BIT   7
`define DPG_PUMP_MODE_BIT    6
`define DPG_PUMP_SET_MSB     2
`define DPG_DIR_BIT          7
`define DPG_COARSE_MSB       3

// ****************************************
// Reset values
// ****************************************
`define DPG_RST_BYTE         8'h00
// Arbitrary neutral revision value
`define DPG_REVISION_VALUE   8'h01

// ****************************************
// Charge pump bias codes and currents in microamps
// ****************************************
`define DPG_PUMP_UA_000      10'h032
`define DPG_PUMP_UA_001      10'h064
`define DPG_PUMP_UA_010      10'h0c8
`define DPG_PUMP_UA_011      10'h190
`define DPG_PUMP_UA_111      10'h320
`define DPG_PUMP_UA_NONE     10'h000

`endif

/* File: dpg_host.sv */
// Serial host controller model driving the register strobe bus
`timescale 1ns/1ps
module dpg_host (
  input  wire logic               clk_sys,
  input  wire dpg_pkg::dpg_byte_t rd_data,
  output logic                    wr_en,
  output logic                    rd_en,
  output dpg_pkg::dpg_byte_t      addr,
  output dpg_pkg::dpg_byte_t      wr_data
);
  import dpg_pkg::*;

  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  // Idle lines show the inverse of the last value so a stale address never looks valid
  task automatic wr(input dpg_byte_t a, input dpg_byte_t d);
    @(posedge clk_sys);
    #1;
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(posedge clk_sys);
    #1;
    wr_en = 1'b0;
    addr = ~a;
    wr_data = ~d;
  endtask
  // Read data is registered at the strobe edge and held, so it is taken just after it
  task automatic rd(input dpg_byte_t a, output dpg_byte_t d);
    @(posedge clk_sys);
    #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge clk_sys);
    #1;
    rd_en = 1'b0;
    addr = ~a;
    d = rd_data;
  endtask
endmodule

/* File: dpg_pkg.sv */
// Types shared by the PLL, gain and offset register bank
package dpg_pkg;
  typedef logic [7:0] dpg_byte_t;
  typedef logic [9:0] dpg_offset_t;
  typedef logic [9:0] dpg_bias_ua_t;
endpackage

/* File: dpg_regs.sv */
// PLL control, channel gain and offset configuration registers at 0x04 to 0x0d
// Functional notes
// - The PLL is enabled only while bit 7 of the PLL control register is 1, and reset leaves it off.
// - Each channel offset magnitude is 10 bits, bits 9..2 from the high register, bits 1..0 from the next.
// - Bit 7 of each second offset register steers the offset to the first terminal at 0, complementary at 1.
// - Reset loads every field with its default, so the PLL is off, the pump automatic and offset on the first terminal.
// - Fine gain at 0x05 and 0x09 is an 8-bit unsigned value with bit 7 as its MSB.
// - Coarse gain at 0x06 and 0x0a is a 4-bit unsigned value in bits 3..0.
// - In programmable mode pump codes 000,001,010,011,111 map to 50,100,200,400,800 microamps.
`timescale 1ns/1ps
`include "dpg_cfg.svh"

module dpg_regs (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               reg_wr_en,
  input  wire logic               reg_rd_en,
  input  wire dpg_pkg::dpg_byte_t reg_addr,
  input  wire dpg_pkg::dpg_byte_t reg_wr_data,
  output dpg_pkg::dpg_byte_t      reg_rd_data,
  output logic                    reg_hit,
  output logic                    pll_enable,
  output logic                    pump_manual,
  output logic [2:0]              pump_setting,
  output dpg_pkg::dpg_bias_ua_t   pump_bias_ua,
  output dpg_pkg::dpg_byte_t      in_phase_converter_fine_gain,
  output logic [3:0]              in_phase_converter_coarse_gain,
  output dpg_pkg::dpg_offset_t    in_phase_converter_offset_current,
  output logic                    in_phase_converter_offset_on_complementary,
  output dpg_pkg::dpg_byte_t      quadrature_converter_fine_gain,
  output logic [3:0]              quadrature_converter_coarse_gain,
  output dpg_pkg::dpg_offset_t    quadrature_converter_offset_current,
  output logic                    quadrature_converter_offset_on_complementary
);
  import dpg_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  dpg_byte_t pll_control_q;
  dpg_byte_t i_fine_q;
  dpg_byte_t i_coarse_q;
  dpg_byte_t i_off_hi_q;
  dpg_byte_t i_off_lo_q;
  dpg_byte_t q_fine_q;
  dpg_byte_t q_coarse_q;
  dpg_byte_t q_off_hi_q;
  dpg_byte_t q_off_lo_q;
  dpg_byte_t rd_data_q;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic wr_hit(input logic en, input dpg_byte_t a, input dpg_byte_t target);
    wr_hit = en && (a == target);
  endfunction

  function automatic dpg_offset_t offset_join(input dpg_byte_t hi, input dpg_byte_t lo);
    offset_join = {hi, lo[1:0]};
  endfunction

  function automatic logic addr_mapped(input dpg_byte_t a);
    addr_mapped = (a >= `DPG_ADDR_PLL_CONTROL) && (a <= `DPG_ADDR_REVISION_ID);
  endfunction

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pll_control_q <= `DPG_RST_BYTE;
    end else if (wr_hit(reg_wr_en, reg_addr, `DPG_ADDR_PLL_CONTROL)) begin
      pll_control_q <= reg_wr_data;
    end
  end

  // Full bytes are stored so unused bits read back as written, like any scratch bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      i_fine_q   <= `DPG_RST_BYTE;
      i_coarse_q <= `DPG_RST_BYTE;
      i_off_hi_q <= `DPG_RST_BYTE;
      i_off_lo_q <= `DPG_RST_BYTE;
    end else begin
      if (wr_hit(reg_wr_en, reg_addr, `DPG_ADDR_I_FINE_GAIN)) begin
        i_fine_q <= reg_wr_data;
      end
      if (wr_hit(reg_wr_en, reg_addr, `DPG_ADDR_I_COARSE_GAIN)) begin
        i_coarse_q <= reg_wr_data;
      end
      if (wr_hit(reg_wr_en, reg_addr, `DPG_ADDR_I_OFFSET_HIGH)) begin
        i_off_hi_q <= reg_wr_data;
      end
      if (wr_hit(reg_wr_en, reg_addr, `DPG_ADDR_I_OFFSET_LOW_DIR)) begin
        i_off_lo_q <= reg_wr_data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_fine_q   <= `DPG_RST_BYTE;
      q_coarse_q <= `DPG_RST_BYTE;
      q_off_hi_q <= `DPG_RST_BYTE;
      q_off_lo_q <= `DPG_RST_BYTE;
    end else begin
      if (wr_hit(reg_wr_en, reg_addr, `DPG_ADDR_Q_FINE_GAIN)) begin
        q_fine_q <= reg_wr_data;
      end
      if (wr_hit(reg_wr_en, reg_addr, `DPG_ADDR_Q_COARSE_GAIN)) begin
        q_coarse_q <= reg_wr_data;
      end
      if (wr_hit(reg_wr_en, reg_addr, `DPG_ADDR_Q_OFFSET_HIGH)) begin
        q_off_hi_q <= reg_wr_data;
      end
      if (wr_hit(reg_wr_en, reg_addr, `DPG_ADDR_Q_OFFSET_LOW_DIR)) begin
        q_off_lo_q <= reg_wr_data;
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Registered read data, one cycle after the strobe; the version address has no storage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_q <= `DPG_RST_BYTE;
    end else if (reg_rd_en) begin
      unique case (reg_addr)
        `DPG_ADDR_PLL_CONTROL:      rd_data_q <= pll_control_q;
        `DPG_ADDR_I_FINE_GAIN:      rd_data_q <= i_fine_q;
        `DPG_ADDR_I_COARSE_GAIN:    rd_data_q <= i_coarse_q;
        `DPG_ADDR_I_OFFSET_HIGH:    rd_data_q <= i_off_hi_q;
        `DPG_ADDR_I_OFFSET_LOW_DIR: rd_data_q <= i_off_lo_q;
        `DPG_ADDR_Q_FINE_GAIN:      rd_data_q <= q_fine_q;
        `DPG_ADDR_Q_COARSE_GAIN:    rd_data_q <= q_coarse_q;
        `DPG_ADDR_Q_OFFSET_HIGH:    rd_data_q <= q_off_hi_q;
        `DPG_ADDR_Q_OFFSET_LOW_DIR: rd_data_q <= q_off_lo_q;
        `DPG_ADDR_REVISION_ID:      rd_data_q <= `DPG_REVISION_VALUE;
        default:                    rd_data_q <= `DPG_RST_BYTE;
      endcase
    end
  end

  assign reg_rd_data = rd_data_q;
  assign reg_hit     = addr_mapped(reg_addr);

  // ****************************************
  // Control outputs
  // ****************************************
  assign pll_enable   = pll_control_q[`DPG_PLL_ENABLE_BIT];
  assign pump_manual  = pll_control_q[`DPG_PUMP_MODE_BIT];
  assign pump_setting = pll_control_q[`DPG_PUMP_SET_MSB:0];

  // Undocumented codes give zero so the analog side falls back to its own default
  always_comb begin
    pump_bias_ua = `DPG_PUMP_UA_NONE;
    if (pump_manual) begin
      unique case (pump_setting)
        3'b000:  pump_bias_ua = `DPG_PUMP_UA_000;
        3'b001:  pump_bias_ua = `DPG_PUMP_UA_001;
        3'b010:  pump_bias_ua = `DPG_PUMP_UA_010;
        3'b011:  pump_bias_ua = `DPG_PUMP_UA_011;
        3'b111:  pump_bias_ua = `DPG_PUMP_UA_111;
        default: pump_bias_ua = `DPG_PUMP_UA_NONE;
      endcase
    end
  end

  assign in_phase_converter_fine_gain   = i_fine_q;
  assign quadrature_converter_fine_gain = q_fine_q;
  assign in_phase_converter_coarse_gain   = i_coarse_q[`DPG_COARSE_MSB:0];
  assign quadrature_converter_coarse_gain = q_coarse_q[`DPG_COARSE_MSB:0];
  assign in_phase_converter_offset_current   = offset_join(i_off_hi_q, i_off_lo_q);
  assign quadrature_converter_offset_current = offset_join(q_off_hi_q, q_off_lo_q);
  assign in_phase_converter_offset_on_complementary   = i_off_lo_q[`DPG_DIR_BIT];
  assign quadrature_converter_offset_on_complementary = q_off_lo_q[`DPG_DIR_BIT];

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_pll_wr_on;
    reg_wr_en && reg_addr == `DPG_ADDR_PLL_CONTROL && reg_wr_data[7];
  endsequence

  property p_pll_on;
    @(posedge clk_sys) disable iff (rst) s_pll_wr_on |=> pll_enable;
  endproperty
  a_pll_on: assert property (p_pll_on) else $error("PLL not enabled after write");

  property p_auto_bias;
    @(posedge clk_sys) disable iff (rst) !pump_manual |-> pump_bias_ua == 10'h000;
  endproperty
  a_auto_bias: assert property (p_auto_bias) else $error("Bias set in automatic mode");

  property p_offset_join;
    @(posedge clk_sys) disable iff (rst)
      reg_wr_en && reg_addr == `DPG_ADDR_I_OFFSET_LOW_DIR ##1 !reg_wr_en
      |-> in_phase_converter_offset_current[1:0] == $past(reg_wr_data[1:0], 1);
  endproperty
  a_offset_join: assert property (p_offset_join) else $error("Offset low bits wrong");

  property p_dir;
    @(posedge clk_sys) disable iff (rst)
      reg_wr_en && reg_addr == `DPG_ADDR_Q_OFFSET_LOW_DIR |=>
      quadrature_converter_offset_on_complementary == $past(reg_wr_data[7]);
  endproperty
  a_dir: assert property (p_dir) else $error("Offset direction wrong");

  property p_reset;
    @(posedge clk_sys) rst |=> !pll_enable && !pump_manual && !in_phase_converter_offset_on_complementary;
  endproperty
  a_reset: assert property (p_reset) else $error("Defaults not loaded");

  property p_fine;
    @(posedge clk_sys) disable iff (rst)
      reg_wr_en && reg_addr == `DPG_ADDR_Q_FINE_GAIN |=> quadrature_converter_fine_gain == $past(reg_wr_data);
  endproperty
  a_fine: assert property (p_fine) else $error("Fine gain not stored");

  property p_coarse;
    @(posedge clk_sys) disable iff (rst)
      reg_wr_en && reg_addr == `DPG_ADDR_I_COARSE_GAIN |=> in_phase_converter_coarse_gain == $past(reg_wr_data[3:0]);
  endproperty
  a_coarse: assert property (p_coarse) else $error("Coarse gain not stored");

  property p_bias_max;
    @(posedge clk_sys) disable iff (rst) pump_manual && pump_setting == 3'b111 |-> pump_bias_ua == 10'h320;
  endproperty
  a_bias_max: assert property (p_bias_max) else $error("Bias code 111 wrong");

  property p_rev;
    @(posedge clk_sys) disable iff (rst)
      reg_rd_en && reg_addr == `DPG_ADDR_REVISION_ID |=> reg_rd_data == `DPG_REVISION_VALUE;
  endproperty
  a_rev: assert property (p_rev) else $error("Revision read wrong");
endmodule

/* File: tb_top.sv */
// Self-checking bench for the PLL, gain and offset register bank
`timescale 1ns/1ps
module tb_top;
  import dpg_pkg::*;
  logic         clk_sys;
  logic         rst;
  logic         wr_en;
  logic         rd_en;
  dpg_byte_t    addr;
  dpg_byte_t    wr_data;
  dpg_byte_t    rd_data;
  dpg_byte_t    v;
  logic         pll;
  logic         man;
  logic [2:0]   pset;
  dpg_bias_ua_t bias;
  dpg_byte_t    ifg;
  dpg_byte_t    qfg;
  logic [3:0]   icg;
  logic [3:0]   qcg;
  dpg_offset_t  ioc;
  dpg_offset_t  qoc;
  logic         iocmp;
  logic         qocmp;
  logic         hit;
  logic         hit_seen;
  int           n_mismatch;
  int           n_checks;
  logic [9:0]   ua [8] = '{10'h032, 10'h064, 10'h0c8, 10'h190, 10'h000, 10'h000, 10'h000, 10'h320};

  dpg_regs dpg_regs_inst (.clk_sys(clk_sys), .rst(rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wr_data(wr_data), .reg_rd_data(rd_data), .reg_hit(hit), .pll_enable(pll), .pump_manual(man),
    .pump_setting(pset), .pump_bias_ua(bias), .in_phase_converter_fine_gain(ifg),
    .in_phase_converter_coarse_gain(icg), .in_phase_converter_offset_current(ioc),
    .in_phase_converter_offset_on_complementary(iocmp), .quadrature_converter_fine_gain(qfg),
    .quadrature_converter_coarse_gain(qcg), .quadrature_converter_offset_current(qoc),
    .quadrature_converter_offset_on_complementary(qocmp));
  dpg_host dpg_host_inst (.clk_sys(clk_sys), .rd_data(rd_data), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data));

  // Address decode is only meaningful while a strobe is up, so it is caught at that edge
  always @(posedge clk_sys) begin
    if (wr_en || rd_en) begin
      hit_seen <= hit;
    end
  end

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input dpg_byte_t a, input dpg_byte_t exp);
    dpg_host_inst.rd(a, v);
    chk({2'b00, v}, {2'b00, exp});
  endtask
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_defaults;
    chk({pll, man, pset, iocmp, qocmp, 3'b000}, 10'h000);
    chk({icg, qcg, 2'b00}, 10'h000);
    chk({ifg, 2'b00} | {2'b00, qfg}, 10'h000);
    chk(ioc, 10'h000);
    chk(qoc | bias, 10'h000);
    for (int a = 4; a < 13; a++) rchk(a[7:0], 8'h00);
    rchk(8'h0d, 8'h01);
    $display("Test defaults done");
  endtask
  task automatic t_pll;
    dpg_host_inst.wr(8'h04, 8'h80);
    chk({pll, man, bias[7:0]}, 10'h200);
    for (int c = 0; c < 8; c++) begin
      dpg_host_inst.wr(8'h04, {5'b01000, c[2:0]});
      chk({pll, man, pset, 5'b00000}, {5'b01000 | c[4:0], 5'b00000} >> 3 << 3 | {2'b01, c[2:0], 5'b0});
      chk(bias, ua[c]);
    end
    rchk(8'h04, 8'h47);
    $display("Test pll done");
  endtask
  task automatic t_gain_offset;
    dpg_host_inst.wr(8'h05, 8'ha5);
    dpg_host_inst.wr(8'h09, 8'h5a);
    dpg_host_inst.wr(8'h06, 8'hfc);
    dpg_host_inst.wr(8'h0a, 8'h03);
    chk({ifg, 2'b00}, 10'h294);
    chk({2'b00, qfg}, 10'h05a);
    chk({icg, qcg, 2'b00}, 10'h30c);
    rchk(8'h06, 8'hfc);
    dpg_host_inst.wr(8'h07, 8'hff);
    dpg_host_inst.wr(8'h08, 8'h82);
    dpg_host_inst.wr(8'h0b, 8'h01);
    dpg_host_inst.wr(8'h0c, 8'h03);
    chk(ioc, 10'h3fe);
    chk(qoc, 10'h007);
    chk({iocmp, qocmp, 8'h00}, 10'h200);
    $display("Test gain offset done");
  endtask
  task automatic t_read_only;
    dpg_host_inst.wr(8'h0d, 8'hff);
    rchk(8'h0d, 8'h01);
    dpg_host_inst.wr(8'h0e, 8'h55);
    rchk(8'h0e, 8'h00);
    chk({9'h000, hit_seen}, 10'h000);
    rchk(8'h05, 8'ha5);
    chk({9'h000, hit_seen}, 10'h001);
    $display("Test read only done");
  endtask

  always #12.5 clk_sys = ~clk_sys;
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    n_mismatch = 0;
    n_checks = 0;
    repeat (8) @(posedge clk_sys);
    #1 rst = 1'b0;
    t_defaults();
    t_pll();
    t_gain_offset();
    t_read_only();
    // A second reset in mid-run must bring every field back to its default
    @(posedge clk_sys);
    #1 rst = 1'b1;
    @(posedge clk_sys);
    #1 rst = 1'b0;
    t_defaults();
    complete_run();
  end
endmodule
